// ===== logic/pwm_dac_pkg.sv
/*
 * shared constants, carrier types and step decoding for the dual
 * pulse length dac.
 * assumes a 32-bit axi4-lite register bus and a 250 mhz cpu clock.
 */
package pwm_dac_pkg;

    // bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int DUTY_W = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DUTY_A = 8'h0A;
    localparam logic [7:0] IDX_DUTY_B = 8'h0B;
    localparam logic [7:0] IDX_MISC = 8'h0C;
    localparam logic [7:0] IDX_STATUS = 8'h0D;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_A = {2'b00, IDX_DUTY_A, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DUTY_B = {2'b00, IDX_DUTY_B, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MISC = {2'b00, IDX_MISC, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

    // misc control field positions
    localparam int BIT_RATE_A = 3;
    localparam int BIT_RATE_B = 2;
    localparam int BIT_SLOW_MODE = 1;

    // status field positions
    localparam int STAT_OUT_A = 0;
    localparam int STAT_OUT_B = 1;
    localparam int STAT_STOPPED = 2;

    // reset values
    localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;

    // timebase figures, in cpu clocks and timer clocks
    localparam int CPU_PER_TIMER = 4;
    localparam int BUS_SLOW_DIV = 16;
    localparam int FAST_CYCLE = 256;
    localparam int SLOW_CYCLE = 4096;
    localparam int STEP_FAST_CPU = 4;
    localparam int STEP_SLOW_CPU = 64;
    localparam int STEP_SLOW_TIMER = STEP_SLOW_CPU / CPU_PER_TIMER;
    localparam int SLOW_SHIFT = $clog2(STEP_SLOW_TIMER);
    localparam int COUNT_W = $clog2(SLOW_CYCLE);

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // shared timer counter and its advance strobe
    typedef struct packed {
        logic tick;
        logic [COUNT_W-1:0] count;
    } timebase_t;

    // per-channel settings from software
    typedef struct packed {
        logic slow;
        logic [DUTY_W-1:0] duty;
    } chan_cfg_t;

    // step within the cycle: one timer clock fast, sixteen slow
    function automatic logic [DUTY_W-1:0] step_index(
        input logic [COUNT_W-1:0] c,
        input logic slow
    );
        logic [COUNT_W-1:0] shifted;
        shifted = c >> SLOW_SHIFT;
        step_index = slow ? shifted[DUTY_W-1:0] : c[DUTY_W-1:0];
    endfunction

    // last timer clock of a repetition cycle
    function automatic logic cycle_end(
        input logic [COUNT_W-1:0] c,
        input logic slow
    );
        cycle_end = slow ? (c == COUNT_W'(SLOW_CYCLE - 1))
                         : (c[DUTY_W-1:0] == DUTY_W'(FAST_CYCLE - 1));
    endfunction

endpackage

// ===== logic/timer_prescaler.sv
/*
 * bus clock slow-down, divide-by-four timer clock and the shared
 * free-running timer counter that paces both channels.
 * assumes run already folds in clock enable and stop.
 */
`timescale 1ns/1ps
module timer_prescaler
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // control
    input wire logic run,
    input wire logic slowMode,
    input wire logic timerReset,
    // timebase out
    output pwm_dac_pkg::timebase_t tb
);
    import pwm_dac_pkg::*;

    logic [3:0] busDiv_q; // slow-mode bus divider
    logic [1:0] preDiv_q; // cpu to timer divider
    logic [COUNT_W-1:0] count_q; // timer counter
    logic cpuTick; // one effective cpu clock
    logic timerTick; // one timer clock

    // slow mode lets one cpu clock through in sixteen
    assign cpuTick = !slowMode || (busDiv_q == 4'(BUS_SLOW_DIV - 1));
    // timer clock every fourth cpu clock
    assign timerTick = cpuTick && (preDiv_q == 2'(CPU_PER_TIMER - 1));

    // bus divider
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            busDiv_q <= 4'h0;
        else if (run)
            busDiv_q <= slowMode ? busDiv_q + 4'h1 : 4'h0;
    end

    // prescaler and counter; a timer reset shifts both channels
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            preDiv_q <= 2'b00;
            count_q <= '0;
        end
        else if (run)
        begin
            if (timerReset)
            begin
                preDiv_q <= 2'b00;
                count_q <= '0;
            end
            else if (cpuTick)
            begin
                preDiv_q <= preDiv_q + 2'b01;
                if (timerTick)
                    count_q <= count_q + COUNT_W'(1);
            end
        end
    end

    // the strobe is gated so a frozen or cleared timer loads no duty
    assign tb = '{tick: run && !timerReset && timerTick, count: count_q};

endmodule // timer_prescaler

// ===== logic/pwm_channel.sv
/*
 * one pulse length channel: active duty buffer and output compare.
 * assumes the shared timebase and a run enable from the top.
 */
`timescale 1ns/1ps
module pwm_channel
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // timebase and settings
    input wire logic run,
    input pwm_dac_pkg::timebase_t tb,
    input pwm_dac_pkg::chan_cfg_t cfg,
    // output pin level
    output logic pinOut
);
    import pwm_dac_pkg::*;

    logic [DUTY_W-1:0] active_q; // duty in use this cycle
    logic [DUTY_W-1:0] stepNow; // step within the cycle

    // 256 steps in either rate
    assign stepNow = step_index(tb.count, cfg.slow);

    // buffered duty taken only at the end of a whole cycle
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            active_q <= DUTY_RESET;
        else if (tb.tick && cycle_end(tb.count, cfg.slow))
            active_q <= cfg.duty;
    end

    // high while step below duty; held when not running
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pinOut <= 1'b0;
        else if (run)
            pinOut <= stepNow < active_q;
    end

endmodule // pwm_channel

// ===== logic/pwm_dac_top.sv
/*
 * dual pulse length dac: axi4-lite register slave, stop handling,
 * system slow mode bit and the two channel instances.
 * assumes axi signals on the clock domain; stopRequest is an
 * asynchronous pin; timerReset comes from timer logic on this clock.
 */
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps

module pwm_dac_top
(
    // clock, reset and enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clockEnable,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [pwm_dac_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [pwm_dac_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [pwm_dac_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [pwm_dac_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // device state and timer
    input wire logic stopRequest,
    input wire logic timerReset,
    // outputs
    output logic pwmChannelA,
    output logic pwmChannelB,
    output logic systemSlowMode
);
    import pwm_dac_pkg::*;

    // write channel capture
    logic awHave_q; // address held
    logic wHave_q; // data held
    logic [ADDR_W-1:0] awAddr_q; // held write address
    logic [DUTY_W-1:0] wByte_q; // held low data byte
    logic wLane_q; // low byte lane enabled
    logic doWrite; // both halves present, response free

    // software registers
    logic [DUTY_W-1:0] dutyA_q; // buffered duty a
    logic [DUTY_W-1:0] dutyB_q; // buffered duty b
    logic rateSelectA_q; // channel a slow rate
    logic rateSelectB_q; // channel b slow rate
    logic slowMode_q; // system slow mode

    // stop pin synchroniser and edge
    logic stopMeta_q; // first stage, read only by the second
    logic stopSync_q; // second stage
    logic stopPrev_q; // previous synchronised level
    logic stopEntry; // rising edge of stop

    // running state
    logic run; // clock enabled and not stopped
    timebase_t tb; // shared timer
    chan_cfg_t cfgA; // channel a settings
    chan_cfg_t cfgB; // channel b settings
    logic [DUTY_W-1:0] readByte; // decoded read value
    logic readHit; // read address mapped
    logic writeHit; // write address mapped

    // address decode shared by both directions
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == ADDR_DUTY_A) || (a == ADDR_DUTY_B)
              || (a == ADDR_MISC) || (a == ADDR_STATUS);
    endfunction

    //------------------------------------------------------------
    // stop pin: two flip-flops, then an edge detector on the second
    // the first stage may go metastable, so only the second reads it
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stopMeta_q <= 1'b0;
            stopSync_q <= 1'b0;
            stopPrev_q <= 1'b0;
        end
        else if (clockEnable)
        begin
            stopMeta_q <= stopRequest;
            stopSync_q <= stopMeta_q;
            stopPrev_q <= stopSync_q;
        end
    end

    // entry to stop seen once per request
    assign stopEntry = stopSync_q && !stopPrev_q;

    // there is no wait input: wait leaves the timebase running
    // stop freezes timebase and outputs; wait has no hold here
    assign run = clockEnable && !stopSync_q;

    //------------------------------------------------------------
    // write handshakes: ready while the slot is empty
    // a held half refuses a second one until doWrite consumes it
    assign awready = clockEnable && !awHave_q;
    assign wready = clockEnable && !wHave_q;
    assign doWrite = clockEnable && awHave_q && wHave_q && !bvalid;
    assign writeHit = mapped(awAddr_q);

    // capture write address, in either order with the data
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHave_q <= 1'b0;
            awAddr_q <= '0;
        end
        else if (clockEnable)
        begin
            if (awvalid && awready)
            begin
                awHave_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            else if (doWrite)
                awHave_q <= 1'b0;
        end
    end

    // capture write data and its low byte lane
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wHave_q <= 1'b0;
            wByte_q <= '0;
            wLane_q <= 1'b0;
        end
        else if (clockEnable)
        begin
            if (wvalid && wready)
            begin
                wHave_q <= 1'b1;
                wByte_q <= wdata[DUTY_W-1:0];
                wLane_q <= wstrb[0];
            end
            else if (doWrite)
                wHave_q <= 1'b0;
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (clockEnable)
        begin
            if (doWrite)
            begin
                bvalid <= 1'b1;
                bresp <= writeHit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // duty registers: writes land in the buffer only
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dutyA_q <= DUTY_RESET;
            dutyB_q <= DUTY_RESET;
        end
        else if (doWrite && wLane_q)
        begin
            if (awAddr_q == ADDR_DUTY_A)
                dutyA_q <= wByte_q;
            if (awAddr_q == ADDR_DUTY_B)
                dutyB_q <= wByte_q;
        end
    end

    // a mid-cycle change moves the step index at once, so software
    // must settle the rates before it loads new duty values
    // rate selects act at once, with no buffer
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rateSelectA_q <= 1'b0;
            rateSelectB_q <= 1'b0;
        end
        else if (doWrite && wLane_q && awAddr_q == ADDR_MISC)
        begin
            rateSelectA_q <= wByte_q[BIT_RATE_A];
            rateSelectB_q <= wByte_q[BIT_RATE_B];
        end
    end

    // system slow mode; stop entry clears it ahead of software
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            slowMode_q <= 1'b0;
        else if (clockEnable)
        begin
            if (stopEntry)
                slowMode_q <= 1'b0;
            else if (doWrite && wLane_q && awAddr_q == ADDR_MISC)
                slowMode_q <= wByte_q[BIT_SLOW_MODE];
        end
    end

    // bus clock select out: high means sixteen times slower
    assign systemSlowMode = slowMode_q;

    //------------------------------------------------------------
    // read handshake: one read in flight
    assign arready = clockEnable && !rvalid;
    assign readHit = mapped(araddr);

    // read value decode; unused bits read as zero
    // status bits are live levels, taken when the address is accepted
    always_comb
    begin
        readByte = '0;
        unique case (araddr)
            ADDR_DUTY_A: readByte = dutyA_q;
            ADDR_DUTY_B: readByte = dutyB_q;
            ADDR_MISC:
            begin
                readByte[BIT_RATE_A] = rateSelectA_q;
                readByte[BIT_RATE_B] = rateSelectB_q;
                readByte[BIT_SLOW_MODE] = slowMode_q;
            end
            ADDR_STATUS:
            begin
                readByte[STAT_OUT_A] = pwmChannelA;
                readByte[STAT_OUT_B] = pwmChannelB;
                readByte[STAT_STOPPED] = stopSync_q;
            end
            default: readByte = '0;
        endcase
    end

    // read data registered one cycle after the address is taken
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end
        else if (clockEnable)
        begin
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rdata <= {{(DATA_W - DUTY_W){1'b0}}, readByte};
                rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rready)
                rvalid <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // the prescaler sees run, so stop and clock enable freeze it too
    // shared timer: slow mode, divide by four, counter
    timer_prescaler u_timer
    (
        .clock(clock),
        .reset_n(reset_n),
        .run(run),
        .slowMode(slowMode_q),
        .timerReset(timerReset),
        .tb(tb)
    );

    // channel settings; duty is buffered again inside each channel
    assign cfgA = '{slow: rateSelectA_q, duty: dutyA_q};
    assign cfgB = '{slow: rateSelectB_q, duty: dutyB_q};

    // channel a on the shared timer
    pwm_channel u_chanA
    (
        .clock(clock),
        .reset_n(reset_n),
        .run(run),
        .tb(tb),
        .cfg(cfgA),
        .pinOut(pwmChannelA)
    );

    // channel b on the shared timer
    pwm_channel u_chanB
    (
        .clock(clock),
        .reset_n(reset_n),
        .run(run),
        .tb(tb),
        .cfg(cfgB),
        .pinOut(pwmChannelB)
    );

endmodule // pwm_dac_top

// ===== testbench/pwm_dac_assertions.sv
/* checker on the top ports of the dual pwm dac.
   assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ps
module pwm_dac_assertions
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // bus handshakes
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [pwm_dac_pkg::DATA_W-1:0] rdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    // device state and pins
    input wire logic stopRequest,
    input wire logic timerReset,
    input wire logic pwmChannelA,
    input wire logic pwmChannelB,
    input wire logic systemSlowMode
);
    import pwm_dac_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_reset_outs: assert property ($rose(reset_n) |->
        !pwmChannelA && !pwmChannelB)
        else $error("pins not low after reset");
    a_reset_slow: assert property ($rose(reset_n) |->
        !systemSlowMode) else $error("slow mode set after reset");
    a_stop_holds_a: assert property (stopRequest[*5] |->
        $stable(pwmChannelA)) else $error("pin a moved in stop");
    a_stop_holds_b: assert property (stopRequest[*5] |->
        $stable(pwmChannelB)) else $error("pin b moved in stop");
    a_stop_clears_slow: assert property (stopRequest[*5] |->
        !systemSlowMode) else $error("slow mode kept in stop");
    // a step lasts at least four clocks unless the timer is cleared
    a_step_min_a: assert property (disable iff (!reset_n || timerReset)
        $changed(pwmChannelA) |=> $stable(pwmChannelA)[*3])
        else $error("pin a step too short");
    a_step_min_b: assert property (disable iff (!reset_n || timerReset)
        $changed(pwmChannelB) |=> $stable(pwmChannelB)[*3])
        else $error("pin b step too short");
    a_slow_by_write: assert property ($rose(systemSlowMode) |->
        $rose(bvalid)) else $error("slow mode set without write");
    a_read_width: assert property (rvalid |->
        rdata[31:8] == 24'h00_0000) else $error("read upper bits set");
    a_read_lat: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_resp_holds: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp)) else $error("write response dropped");
endmodule // pwm_dac_assertions

bind pwm_dac_top pwm_dac_assertions chk (.*);

// ===== testbench/pwm_load.sv
/* external load model: integrates high time and counts rising edges
   of both pwm pins over a window. assumes clear on the bench clock. */
`timescale 1ns/1ps
module pwm_load
(
    // clock and window control
    input wire logic clock,
    input wire logic clear,
    // pins from the block
    input wire logic pinA,
    input wire logic pinB,
    // integrated results
    output logic [31:0] highA,
    output logic [31:0] highB,
    output logic [31:0] risesA,
    output logic [31:0] risesB
);
    logic prevA; // last level of pin a
    logic prevB; // last level of pin b
    // accumulate each sample, restart the window on clear
    always @(posedge clock)
    begin
        if (clear)
        begin
            highA <= '0;
            highB <= '0;
            risesA <= '0;
            risesB <= '0;
        end
        else
        begin
            highA <= highA + 32'(pinA);
            highB <= highB + 32'(pinB);
            risesA <= risesA + 32'(pinA && !prevA);
            risesB <= risesB + 32'(pinB && !prevB);
        end
        prevA <= pinA;
        prevB <= pinB;
    end
endmodule // pwm_load

// ===== testbench/tb_top.sv
/* self-checking bench for the dual pwm dac over axi4-lite.
   assumes the design and load model files are compiled first. */
`timescale 1ns/1ps
module tb_top;
    import pwm_dac_pkg::*;
    logic clock = 1'b0;
    logic reset_n, clockEnable, awvalid, wvalid, bready, arvalid, rready;
    logic stopRequest, timerReset, clear;
    logic awready, wready, bvalid, arready, rvalid;
    logic pwmChannelA, pwmChannelB, systemSlowMode;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [2:0] awprot, arprot;
    logic [1:0] bresp, rresp;
    logic [31:0] highA, highB, risesA, risesB;
    int errors, samplesChecked, cycles;
    localparam int FAST_CLK = FAST_CYCLE * CPU_PER_TIMER;
    localparam int SLOW_CLK = SLOW_CYCLE * CPU_PER_TIMER;

    pwm_dac_top uut (.*);
    pwm_load load (.clock(clock), .clear(clear), .pinA(pwmChannelA),
        .pinB(pwmChannelB), .highA(highA), .highB(highB),
        .risesA(risesA), .risesB(risesB));

    always #2 clock = ~clock;

    task wrap_up;
        $display("checked %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            errors++;
            wrap_up;
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write: address and data together, each released when taken;
    // bready rises only once bvalid is seen, so the response must hold
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er = RESP_OKAY);
        bit ad, wd;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clock);
            if (!ad && awready)
            begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready)
            begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!bvalid);
        bready <= 1'b1;
        do @(posedge clock); while (!bvalid);
        bready <= 1'b0;
        check(32'(bresp), 32'(er));
        @(posedge clock);
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp,
        input logic [1:0] er, input bit cd);
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        check(32'(r), 32'(er));
        if (cd)
            check(d, exp);
        @(posedge clock);
    endtask

    // one window of n samples in the load model
    task measure(input int n);
        @(posedge clock);
        clear <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        repeat (n) @(posedge clock);
        // read the window at the next edge, once its last sample settled
        @(posedge clock);
    endtask

    task test_reset;
        axi_wr(12'h100, 32'h0000_00FF, RESP_SLVERR);
        axi_rd(ADDR_DUTY_A, '0, RESP_OKAY, 1);
        axi_rd(ADDR_DUTY_B, '0, RESP_OKAY, 1);
        axi_rd(ADDR_MISC, '0, RESP_OKAY, 1);
        axi_rd(ADDR_STATUS, '0, RESP_OKAY, 1);
        axi_rd(12'h100, '0, RESP_SLVERR, 0);
        $display("test_reset done");
    endtask

    // fast rate: high time and one rise per 1024 clocks, none at duty zero
    task automatic test_fast;
        logic [7:0] vals [4] = '{8'h00, 8'h80, 8'hFF, 8'h01};
        logic [7:0] v, w;
        foreach (vals[i])
        begin
            v = vals[i];
            w = ~v;
            axi_wr(ADDR_DUTY_A, 32'(v));
            axi_wr(ADDR_DUTY_B, 32'(w));
            repeat (2 * FAST_CLK) @(posedge clock);
            measure(FAST_CLK);
            check(highA, 32'(v) * STEP_FAST_CPU);
            check(highB, 32'(w) * STEP_FAST_CPU);
            check(risesA, 32'(v != 0));
            check(risesB, 32'(w != 0));
        end
        $display("test_fast done");
    endtask

    // slow rate on both channels, rate set before duty
    task test_slow;
        axi_wr(ADDR_MISC, 32'h0000_000C);
        axi_rd(ADDR_MISC, 32'h0000_000C, RESP_OKAY, 1);
        axi_wr(ADDR_DUTY_A, 32'h0000_0040);
        axi_wr(ADDR_DUTY_B, 32'h0000_00C0);
        repeat (SLOW_CLK + 16) @(posedge clock);
        measure(SLOW_CLK);
        check(highA, 32'h0000_0040 * STEP_SLOW_CPU);
        check(highB, 32'h0000_00C0 * STEP_SLOW_CPU);
        check(risesA, 32'h0000_0001);
        check(risesB, 32'h0000_0001);
        $display("test_slow done");
    endtask

    // slow bus mode, stop freeze and clear, resume after stop
    task automatic test_stop;
        logic [1:0] pins;
        axi_wr(ADDR_MISC, 32'h0000_000E);
        check(32'(systemSlowMode), 32'h0000_0001);
        stopRequest <= 1'b1;
        repeat (10) @(posedge clock);
        pins = {pwmChannelA, pwmChannelB};
        repeat (300) @(posedge clock);
        check(32'({pwmChannelA, pwmChannelB}), 32'(pins));
        check(32'(systemSlowMode), '0);
        stopRequest <= 1'b0;
        axi_rd(ADDR_MISC, 32'h0000_000C, RESP_OKAY, 1);
        timerReset <= 1'b1;
        @(posedge clock);
        timerReset <= 1'b0;
        measure(SLOW_CLK);
        check(risesA, 32'h0000_0001);
        check(highB, 32'h0000_00C0 * STEP_SLOW_CPU);
        $display("test_stop done");
    endtask

    initial
    begin
        reset_n = 1'b0;
        clockEnable = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {stopRequest, timerReset, clear} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        awprot = '0;
        arprot = '0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        test_reset;
        test_fast;
        test_slow;
        test_stop;
        wrap_up;
    end
endmodule // tb_top
